// ==== rtl/fafsb_pkg.sv ====
// Purpose: Shared constants for the queue and fault status bank.
// Assumes: 8-bit register port, byte offsets as printed.
// Notes: Imported by every design module.
package fafsb_pkg;
    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Device register offsets
    localparam logic [7:0] OFF_QUEUE_CONFIG_ONE = 8'h16;
    localparam logic [7:0] OFF_QUEUE_CONFIG_TWO = 8'h17;
    localparam logic [7:0] OFF_QUEUE_STATUS = 8'h18;
    localparam logic [7:0] OFF_MODULE_FAULT_STATUS_ONE = 8'h19;
    localparam logic [7:0] OFF_MODULE_FAULT_STATUS_TWO = 8'h1a;
    // Queue status fields
    localparam int QS_READY = 7;
    localparam int QS_EMPTY = 6;
    localparam int QS_FULL = 5;
    localparam int QS_ERROR = 4;
    // Queue configuration fields
    localparam int CFG1_SOFT_RST = 4;
    localparam int CFG1_ENABLE = 0;
    localparam int THR_W = 5;
    localparam int COUNT_W = 4;
    localparam logic [3:0] QUEUE_DEPTH = 4'hc;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [7:0] CFG2_RESET = 8'h00;
    // Module status one fields
    localparam int M1_INVALID = 7;
    localparam int M1_GND_SHORT = 6;
    localparam int M1_CLK_MISS = 5;
    localparam int M1_FRAME = 4;
    localparam int M1_WR_CRC = 3;
    localparam int M1_CMD_CRC = 2;
    localparam int M1_RANGE = 1;
    localparam int M1_PWR_SHORT = 0;
    // Module status two fields
    localparam int M2_BIAS_POS = 7;
    localparam int M2_BIAS_NEG = 6;
    localparam int M2_A2_NEG = 3;
    localparam int M2_A2_POS = 2;
    localparam int M2_A1_NEG = 1;
    localparam int M2_A1_POS = 0;
    // Bits that a written zero clears
    localparam logic [7:0] M1_CLEAR_MASK = 8'h5d;
    localparam logic [7:0] M2_CLEAR_MASK = 8'hcf;
    // Host command register offsets
    localparam logic [7:0] H_OFF_CTRL = 8'h00;
    localparam logic [7:0] H_OFF_TARGET = 8'h01;
    localparam logic [7:0] H_OFF_DATA = 8'h02;
    localparam logic [7:0] H_OFF_RESULT = 8'h03;
    localparam logic [7:0] H_OFF_STATUS = 8'h04;
    // Host control fields
    localparam int HC_WRITE = 0;
    localparam int HC_READ = 1;
    localparam int HC_CLEAR = 2;
    localparam int HC_CRC_EN = 3;
    // Host sequencer states, Gray along each path
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_READ_WAIT = 2'b01,
        HOST_RELEASE = 2'b10
    } fafsb_host_state_type;
endpackage

// ==== rtl/fafsb_reg_if.sv ====
// Purpose: Register port joining host and device.
// Assumes: Read data one cycle after the read strobe.
// Notes: No clock inside; both ends share clk_in.
`timescale 1ns/1ps
`default_nettype none
interface fafsb_reg_if;
    logic [7:0] addr; // Register offset
    logic [7:0] wdata; // Write data
    logic wr; // One-cycle write strobe
    logic rd; // One-cycle read strobe
    logic [7:0] rdata; // Read data, cycle after rd
    // Documented device end
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    // Host end
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ==== rtl/fafsb_sticky_bank.sv ====
// Purpose: Byte of sticky flags, cleared by writing zero.
// Assumes: Set inputs are one-cycle or level events.
// Notes: Bits outside CLEAR_MASK hold until reset.
`timescale 1ns/1ps
`default_nettype none
module fafsb_sticky_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] CLEAR_MASK = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] flags_out
);
    import fafsb_pkg::*;
    logic [WIDTH-1:0] clear_bits; // Bits a write knocks down

    // Only written zeros in clearable lanes clear; ones are ignored
    always_comb begin
        clear_bits = wr_in ? (CLEAR_MASK & ~wdata_in) : '0;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_out <= '0;
        end else begin
            flags_out <= (flags_out & ~clear_bits) | set_in;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/fafsb_device.sv ====
// Purpose: Queue status and module fault status registers.
// Assumes: Queue push and pop arrive as one-cycle strobes.
// Notes: Status bits read live; queue_ready_out lags count by one.
// Functional notes
// - Ready bit set when count reaches threshold.
// - Empty bit reads one, also after reset.
// - Full bit follows full queue, zero at reset.
// - Error set when disabled with unequal pointers.
// - Error cleared by soft-reset write or device reset.
// - Unexpected access disables the queue.
// - Stored item count shown in bits 3:0.
// - Invalid-command flag set by first occurrence only.
// - Host ignores invalid flag under input CRC.
// - Ground short sticky until written zero.
// - Supply short sticky until written zero.
// - Clock-missing flag held until device reset.
// - Frame overwrite sets lost-data flag.
// - Register-write CRC failure sets bit 3.
// - Other command CRC failure sets bit 2.
// - Converter range flag follows current result.
// - Bias-drive lead-off flags sticky, write-zero clear.
// - Amplifier range flags sticky, write-zero clear.
// - Threshold code n means n+1 items.
// - Host writes zero to release soft reset.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fafsb_device #(
    parameter int DEPTH = 12
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    fafsb_reg_if.dev bus,
    input wire logic queue_push_in,
    input wire logic queue_pop_in,
    input wire logic invalid_cmd_in,
    input wire logic pin_ground_short_in,
    input wire logic pin_supply_short_in,
    input wire logic clock_missing_in,
    input wire logic frame_overwrite_in,
    input wire logic write_payload_crc_fail_in,
    input wire logic command_crc_fail_in,
    input wire logic converter_range_in,
    input wire logic bias_drive_pos_leadoff_in,
    input wire logic bias_drive_neg_leadoff_in,
    input wire logic amp_one_pos_range_in,
    input wire logic amp_one_neg_range_in,
    input wire logic amp_two_pos_range_in,
    input wire logic amp_two_neg_range_in,
    output logic queue_ready_out,
    output logic queue_enable_out,
    output logic [fafsb_pkg::COUNT_W-1:0] queue_count_out
);
    import fafsb_pkg::*;

    logic [7:0] queue_config_one; // Enable, soft reset and spare bits
    logic [7:0] queue_config_two; // Selector and threshold
    logic [COUNT_W-1:0] wr_ptr; // Next slot to fill
    logic [COUNT_W-1:0] rd_ptr; // Next slot to drain
    logic [COUNT_W-1:0] queue_fill_count; // Items held
    logic queue_error; // Sticky queue error
    logic converter_range_flag; // Live range flag
    logic [7:0] module_fault_status_one; // Sticky bank one
    logic [7:0] module_fault_status_two; // Sticky bank two
    logic [7:0] set_one; // Set events, bank one
    logic [7:0] set_two; // Set events, bank two
    logic soft_rst; // Queue held in reset
    logic enabled; // Queue accepting traffic
    logic full; // Count at depth
    logic empty; // Count at zero
    logic push_ok; // Push that lands
    logic pop_ok; // Pop that lands
    logic unexpected; // Push when full or pop when empty
    logic cfg1_wr; // Write to config one
    logic cfg2_wr; // Write to config two
    logic [7:0] status_word; // Queue status as read

    // Wrap a pointer at the queue depth
    function automatic logic [COUNT_W-1:0] ptr_step(input logic [COUNT_W-1:0] ptr);
        logic [COUNT_W-1:0] last;
        last = COUNT_W'(DEPTH - 1);
        return (ptr == last) ? '0 : ptr + 1'b1;
    endfunction

    // Decode and queue qualifiers
    always_comb begin
        cfg1_wr = bus.wr && (bus.addr == OFF_QUEUE_CONFIG_ONE);
        cfg2_wr = bus.wr && (bus.addr == OFF_QUEUE_CONFIG_TWO);
        soft_rst = queue_config_one[CFG1_SOFT_RST];
        enabled = queue_config_one[CFG1_ENABLE];
        full = (queue_fill_count == COUNT_W'(DEPTH));
        empty = (queue_fill_count == '0);
        push_ok = queue_push_in && enabled && !soft_rst && !full;
        pop_ok = queue_pop_in && enabled && !soft_rst && !empty;
        // Traffic that cannot be honoured while running
        unexpected = enabled && ((queue_push_in && full) || (queue_pop_in && empty));
    end

    // Config one; hardware disable beats a software write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            queue_config_one <= CFG1_RESET;
        end else begin
            if (cfg1_wr) begin
                queue_config_one <= bus.wdata;
            end
            if (unexpected) begin
                queue_config_one[CFG1_ENABLE] <= 1'b0;
            end
        end
    end

    // Config two holds the ready threshold
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            queue_config_two <= CFG2_RESET;
        end else if (cfg2_wr) begin
            queue_config_two <= bus.wdata;
        end
    end

    // Pointers; soft reset holds them at zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (soft_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= ptr_step(wr_ptr);
            end
            if (pop_ok) begin
                rd_ptr <= ptr_step(rd_ptr);
            end
        end
    end

    // Item count, zero to depth
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            queue_fill_count <= '0;
        end else if (soft_rst) begin
            queue_fill_count <= '0;
        end else if (push_ok && !pop_ok) begin
            queue_fill_count <= queue_fill_count + 1'b1;
        end else if (pop_ok && !push_ok) begin
            queue_fill_count <= queue_fill_count - 1'b1;
        end
    end

    // Error; no set while soft reset zeroes the pointers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            queue_error <= 1'b0;
        end else if (!enabled && !soft_rst && (rd_ptr != wr_ptr)) begin
            queue_error <= 1'b1;
        end else if (soft_rst) begin
            queue_error <= 1'b0;
        end
    end

    // Ready when count exceeds code n, i.e. holds n+1 items
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            queue_ready_out <= 1'b0;
        end else begin
            queue_ready_out <= ({1'b0, queue_fill_count} > queue_config_two[THR_W-1:0]);
        end
    end

    // Range flag tracks the latest result, no latching
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            converter_range_flag <= 1'b0;
        end else begin
            converter_range_flag <= converter_range_in;
        end
    end

    // Event vectors; invalid and clock-miss lanes are not clearable
    always_comb begin
        set_one = '0;
        set_one[M1_INVALID] = invalid_cmd_in;
        set_one[M1_GND_SHORT] = pin_ground_short_in;
        set_one[M1_CLK_MISS] = clock_missing_in;
        set_one[M1_FRAME] = frame_overwrite_in;
        set_one[M1_WR_CRC] = write_payload_crc_fail_in;
        set_one[M1_CMD_CRC] = command_crc_fail_in;
        set_one[M1_PWR_SHORT] = pin_supply_short_in;
        set_two = '0;
        set_two[M2_BIAS_POS] = bias_drive_pos_leadoff_in;
        set_two[M2_BIAS_NEG] = bias_drive_neg_leadoff_in;
        set_two[M2_A2_NEG] = amp_two_neg_range_in;
        set_two[M2_A2_POS] = amp_two_pos_range_in;
        set_two[M2_A1_NEG] = amp_one_neg_range_in;
        set_two[M2_A1_POS] = amp_one_pos_range_in;
    end

    // Sticky fault bank one
    fafsb_sticky_bank #(
        .WIDTH(8),
        .CLEAR_MASK(M1_CLEAR_MASK)
    ) u_bank_one (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(set_one),
        .wr_in(bus.wr && (bus.addr == OFF_MODULE_FAULT_STATUS_ONE)),
        .wdata_in(bus.wdata),
        .flags_out(module_fault_status_one)
    );

    // Sticky fault bank two; reserved lanes never set
    fafsb_sticky_bank #(
        .WIDTH(8),
        .CLEAR_MASK(M2_CLEAR_MASK)
    ) u_bank_two (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .set_in(set_two),
        .wr_in(bus.wr && (bus.addr == OFF_MODULE_FAULT_STATUS_TWO)),
        .wdata_in(bus.wdata),
        .flags_out(module_fault_status_two)
    );

    // Live queue status word
    always_comb begin
        status_word = {4'h0, queue_fill_count};
        status_word[QS_READY] = queue_ready_out;
        status_word[QS_EMPTY] = empty;
        status_word[QS_FULL] = full;
        status_word[QS_ERROR] = queue_error;
    end

    // Read data valid only in the cycle after rd
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus.rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                OFF_QUEUE_CONFIG_ONE: bus.rdata <= queue_config_one;
                OFF_QUEUE_CONFIG_TWO: bus.rdata <= queue_config_two;
                OFF_QUEUE_STATUS: bus.rdata <= status_word;
                OFF_MODULE_FAULT_STATUS_ONE: begin
                    // Range lane is live, the rest sticky
                    bus.rdata <= {module_fault_status_one[7:2], converter_range_flag,
                        module_fault_status_one[0]};
                end
                OFF_MODULE_FAULT_STATUS_TWO: bus.rdata <= module_fault_status_two;
                default: bus.rdata <= 8'h00; // Unmapped reads zero
            endcase
        end else begin
            bus.rdata <= 8'h00;
        end
    end

    // Straight flop copies for the user side
    assign queue_enable_out = queue_config_one[CFG1_ENABLE];
    assign queue_count_out = queue_fill_count;
endmodule
`default_nettype wire

// ==== rtl/fafsb_host.sv ====
// Purpose: Host end issuing reads and writes to the status bank.
// Assumes: Commands come over a plain register port.
// Notes: Commands arriving while busy are dropped.
`timescale 1ns/1ps
`default_nettype none
module fafsb_host (
    input wire logic clk_in,
    input wire logic rst_n_in,
    fafsb_reg_if.host bus,
    input wire logic [fafsb_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [fafsb_pkg::DATA_W-1:0] cmd_wdata_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    output logic [fafsb_pkg::DATA_W-1:0] cmd_rdata_out,
    output logic busy_out
);
    import fafsb_pkg::*;

    fafsb_host_state_type state; // Sequencer state
    logic [7:0] target; // Device offset to access
    logic [7:0] payload; // Data for a device write
    logic [7:0] result; // Last read, filtered
    logic crc_in_enable; // Input CRC checking on
    logic ctrl_wr; // Control write this cycle
    logic rd_seen; // Read issued last cycle

    // Control write decode
    always_comb begin
        ctrl_wr = cmd_wr_in && (cmd_addr_in == H_OFF_CTRL);
    end

    // Target, payload and CRC option
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            target <= 8'h00;
            payload <= 8'h00;
            crc_in_enable <= 1'b0;
        end else if (cmd_wr_in) begin
            if (cmd_addr_in == H_OFF_TARGET) begin
                target <= cmd_wdata_in;
            end
            if (cmd_addr_in == H_OFF_DATA) begin
                payload <= cmd_wdata_in;
            end
            if (ctrl_wr) begin
                crc_in_enable <= cmd_wdata_in[HC_CRC_EN];
            end
        end
    end

    // Sequencer driving the device port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= HOST_IDLE;
            busy_out <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            rd_seen <= 1'b0;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            rd_seen <= bus.rd;
            unique case (state)
                HOST_IDLE: begin
                    if (ctrl_wr && cmd_wdata_in[HC_WRITE]) begin
                        // Plain write; a zero clears sticky flags
                        bus.addr <= target;
                        bus.wdata <= payload;
                        bus.wr <= 1'b1;
                    end else if (ctrl_wr && cmd_wdata_in[HC_READ]) begin
                        bus.addr <= target;
                        bus.rd <= 1'b1;
                        state <= HOST_READ_WAIT;
                        busy_out <= 1'b1;
                    end else if (ctrl_wr && cmd_wdata_in[HC_CLEAR]) begin
                        // Soft reset clears the queue error
                        bus.addr <= OFF_QUEUE_CONFIG_ONE;
                        bus.wdata <= 8'h01 << CFG1_SOFT_RST;
                        bus.wr <= 1'b1;
                        state <= HOST_RELEASE;
                        busy_out <= 1'b1;
                    end
                end
                HOST_READ_WAIT: begin
                    state <= HOST_IDLE;
                    busy_out <= 1'b0;
                end
                HOST_RELEASE: begin
                    // Drop soft reset again; queue left disabled
                    bus.addr <= OFF_QUEUE_CONFIG_ONE;
                    bus.wdata <= 8'h00;
                    bus.wr <= 1'b1;
                    state <= HOST_IDLE;
                    busy_out <= 1'b0;
                end
                default: begin
                    state <= HOST_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // Take read data the cycle after rd; invalid flag void under CRC
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result <= 8'h00;
        end else if (rd_seen) begin
            result <= bus.rdata;
            if (crc_in_enable && (bus.addr == OFF_MODULE_FAULT_STATUS_ONE)) begin
                result[M1_INVALID] <= 1'b0;
            end
        end
    end

    // Command port read data, one cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_rdata_out <= 8'h00;
        end else if (cmd_rd_in) begin
            unique case (cmd_addr_in)
                H_OFF_CTRL: cmd_rdata_out <= {4'h0, crc_in_enable, 3'b000};
                H_OFF_TARGET: cmd_rdata_out <= target;
                H_OFF_DATA: cmd_rdata_out <= payload;
                H_OFF_RESULT: cmd_rdata_out <= result;
                H_OFF_STATUS: cmd_rdata_out <= {7'h00, busy_out};
                default: cmd_rdata_out <= 8'h00;
            endcase
        end else begin
            cmd_rdata_out <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== bench/fafsb_checker.sv ====
// Purpose: Watches the register port between host and device.
// Assumes: Read data stands only in the cycle after rd.
// Notes: Wire only; the bench judges user sides.
`timescale 1ns/1ps
`default_nettype none
module fafsb_checker (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata
);
    import fafsb_pkg::*;
    logic rd_q; // Read taken last cycle
    logic [7:0] addr_q; // Offset of that read
    logic [7:0] seen_one; // Unclearable bits once seen high
    logic qs; // Queue status on the wire now
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    assign qs = rd_q && (addr_q == OFF_QUEUE_STATUS);
    // Track reads and unclearable flags seen high
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            seen_one <= 8'h00;
        end else begin
            rd_q <= rd;
            addr_q <= addr;
            if (rd_q && (addr_q == OFF_MODULE_FAULT_STATUS_ONE)) begin
                seen_one <= seen_one | (rdata & 8'ha0);
            end
        end
    end
    // Two steps of the queue soft reset
    sequence s_soft_set;
        wr && (addr == OFF_QUEUE_CONFIG_ONE) && wdata[CFG1_SOFT_RST];
    endsequence
    sequence s_soft_free;
        wr && (addr == OFF_QUEUE_CONFIG_ONE) && (wdata == 8'h00);
    endsequence
    a_soft_release: assert property (s_soft_set |=> s_soft_free)
        else $error("soft reset not released");
    a_strobe_single: assert property (!(wr && rd))
        else $error("wr and rd together");
    a_read_one_shot: assert property (rd |=> !rd)
        else $error("read strobe too long");
    a_rdata_idle: assert property (!rd_q |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    a_count_range: assert property (qs |-> rdata[3:0] <= QUEUE_DEPTH)
        else $error("item count beyond depth");
    a_empty_count: assert property (qs |-> rdata[QS_EMPTY] == (rdata[3:0] == 4'h0))
        else $error("empty bit disagrees with count");
    a_full_count: assert property (qs |-> rdata[QS_FULL] == (rdata[3:0] == QUEUE_DEPTH))
        else $error("full bit disagrees with count");
    a_sticky_hold: assert property (rd_q && (addr_q == OFF_MODULE_FAULT_STATUS_ONE)
        |-> (rdata & seen_one) == seen_one)
        else $error("unclearable fault flag fell");
    a_reserved_two: assert property (rd_q && (addr_q == OFF_MODULE_FAULT_STATUS_TWO)
        |-> rdata[5:4] == 2'b00)
        else $error("reserved status two bits set");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for host and device.
// Assumes: Host commands are issued only while the host is idle.
// Notes: Device events are one-cycle pulses; converter range is a level.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fafsb_pkg::*;
    logic clk_in; // 100 MHz
    logic rst_n_in; // Async, active low
    logic [7:0] c_addr, c_wdata, c_rdata, d; // Host command port
    logic c_wr, c_rd, busy, push, pop, rng, q_rdy, q_en;
    logic [7:0] ev1, ev2; // Pulses laid out as status bits
    logic [3:0] q_cnt; // Item count port
    int n_mismatch = 0, n_checks = 0;
    fafsb_reg_if bus_if();
    fafsb_device i_fafsb_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
        .queue_push_in(push), .queue_pop_in(pop), .invalid_cmd_in(ev1[7]),
        .pin_ground_short_in(ev1[6]), .pin_supply_short_in(ev1[0]),
        .clock_missing_in(ev1[5]), .frame_overwrite_in(ev1[4]),
        .write_payload_crc_fail_in(ev1[3]), .command_crc_fail_in(ev1[2]),
        .converter_range_in(rng), .bias_drive_pos_leadoff_in(ev2[7]),
        .bias_drive_neg_leadoff_in(ev2[6]), .amp_one_pos_range_in(ev2[0]),
        .amp_one_neg_range_in(ev2[1]), .amp_two_pos_range_in(ev2[2]),
        .amp_two_neg_range_in(ev2[3]), .queue_ready_out(q_rdy),
        .queue_enable_out(q_en), .queue_count_out(q_cnt));
    fafsb_host i_fafsb_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
        .cmd_addr_in(c_addr), .cmd_wdata_in(c_wdata), .cmd_wr_in(c_wr),
        .cmd_rd_in(c_rd), .cmd_rdata_out(c_rdata), .busy_out(busy));
    fafsb_checker i_fafsb_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
        .rdata(bus_if.rdata));
    // Free-running clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One command write
    task hwr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        c_addr <= a;
        c_wdata <= v;
        c_wr <= 1'b1;
        @(posedge clk_in);
        c_wr <= 1'b0;
    endtask
    task hrd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        c_addr <= a;
        c_rd <= 1'b1;
        @(posedge clk_in);
        c_rd <= 1'b0;
        #1 v = c_rdata;
    endtask
    // Bounded wait for the host sequencer
    task idle();
        int i;
        #1;
        for (i = 0; i < 8 && busy !== 1'b0; i++) @(posedge clk_in) #1;
        if (i == 8) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task dwr(input logic [7:0] t, input logic [7:0] v);
        hwr(H_OFF_TARGET, t);
        hwr(H_OFF_DATA, v);
        hwr(H_OFF_CTRL, 8'h01);
        idle();
    endtask
    task dread(input logic [7:0] t, input logic [7:0] crc, output logic [7:0] v);
        hwr(H_OFF_TARGET, t);
        hwr(H_OFF_CTRL, 8'h02 | crc);
        idle();
        hrd(H_OFF_RESULT, v);
    endtask
    task dchk(input logic [7:0] t, input logic [7:0] exp);
        dread(t, 8'h00, d);
        chk($sformatf("reg %h", t), d, exp);
    endtask
    task evt(input logic [7:0] m1, input logic [7:0] m2);
        @(posedge clk_in);
        ev1 <= m1;
        ev2 <= m2;
        @(posedge clk_in);
        ev1 <= 8'h00;
        ev2 <= 8'h00;
    endtask
    // Queue strobes with a gap
    task qop(input int n, input logic is_pop);
        repeat (n) begin
            @(posedge clk_in);
            push <= !is_pop;
            pop <= is_pop;
            @(posedge clk_in);
            push <= 1'b0;
            pop <= 1'b0;
        end
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task t_reset();
        dchk(OFF_QUEUE_STATUS, 8'h40);
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'h00);
        dchk(8'h30, 8'h00);
        dwr(OFF_QUEUE_STATUS, 8'hff);
        dchk(OFF_QUEUE_STATUS, 8'h40);
        $display("test reset done");
    endtask
    task t_queue();
        dwr(OFF_QUEUE_CONFIG_ONE, 8'h01);
        dwr(OFF_QUEUE_CONFIG_TWO, 8'h02);
        qop(2, 1'b0);
        dchk(OFF_QUEUE_STATUS, 8'h02);
        qop(1, 1'b0);
        dchk(OFF_QUEUE_STATUS, 8'h83);
        chk("ready", {7'h00, q_rdy}, 8'h01);
        qop(9, 1'b0);
        dchk(OFF_QUEUE_STATUS, 8'hac);
        qop(1, 1'b0);
        chk("enable", {7'h00, q_en}, 8'h00);
        chk("count", {4'h0, q_cnt}, 8'h0c);
        dchk(OFF_QUEUE_STATUS, 8'hac);
        dwr(OFF_QUEUE_CONFIG_ONE, 8'h01);
        qop(1, 1'b1);
        dwr(OFF_QUEUE_CONFIG_ONE, 8'h00);
        dchk(OFF_QUEUE_STATUS, 8'h9b);
        hwr(H_OFF_CTRL, 8'h04);
        idle();
        dchk(OFF_QUEUE_STATUS, 8'h40);
        dwr(OFF_QUEUE_CONFIG_ONE, 8'h01);
        qop(1, 1'b1);
        chk("enable", {7'h00, q_en}, 8'h00);
        $display("test queue done");
    endtask
    task t_flags();
        @(posedge clk_in);
        rng <= 1'b1;
        evt(8'hfd, 8'h00);
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'hff);
        dwr(OFF_MODULE_FAULT_STATUS_ONE, 8'hff);
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'hff);
        dwr(OFF_MODULE_FAULT_STATUS_ONE, 8'h00);
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'ha2);
        @(posedge clk_in);
        rng <= 1'b0;
        evt(8'h80, 8'h00);
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'ha0);
        dread(OFF_MODULE_FAULT_STATUS_ONE, 8'h08, d);
        chk("masked", d, 8'h20);
        evt(8'h00, 8'hcf);
        dchk(OFF_MODULE_FAULT_STATUS_TWO, 8'hcf);
        dwr(OFF_MODULE_FAULT_STATUS_TWO, 8'hff);
        dchk(OFF_MODULE_FAULT_STATUS_TWO, 8'hcf);
        dwr(OFF_MODULE_FAULT_STATUS_TWO, 8'hf0);
        dchk(OFF_MODULE_FAULT_STATUS_TWO, 8'hc0);
        dwr(OFF_MODULE_FAULT_STATUS_TWO, 8'h00);
        dchk(OFF_MODULE_FAULT_STATUS_TWO, 8'h00);
        $display("test flags done");
    endtask
    // Mid-run reset clears the clock-missing flag
    task t_rerst();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        dchk(OFF_MODULE_FAULT_STATUS_ONE, 8'h00);
        $display("test second reset done");
    endtask
    initial begin
        {c_addr, c_wdata, ev1, ev2, c_wr, c_rd, push, pop, rng} = '0;
        rst_n_in = 1'b0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_queue();
        t_flags();
        t_rerst();
        complete_run();
    end
endmodule
`default_nettype wire
